// ---- hdl/dtp_timer_pair.v ----
// paired 8-bit timers with cascade and pwm modes behind an axi4-lite slave
`timescale 1ns/1ps
`include "dtp_defs.vh"
module dtp_timer_pair #(
  parameter TBC_DIV = `DTP_TBC_CYC
) (
  // clock and reset
  input  wire        clk,
  input  wire        srst,
  // axi4-lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // axi4-lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  // axi4-lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // event inputs and timer outputs
  input  wire        low_event_input,
  input  wire        high_event_input,
  output reg         low_output,
  output reg         high_output,
  // interrupt
  output reg         irq
);

  // ========================================================================
  // register map, one aligned word each, unused upper bits read zero
  //   0x00 low control
  //     [2:0] count clock select
  //     [3]   run
  //     [6:4] absent, read as one
  //     [7]   output level: written as start level, read as live level
  //   0x04 high control
  //     [2:0] count clock select, ignored in cascade
  //     [3]   run, ignored in cascade and pwm
  //     [4]   cascade select
  //     [5]   pulse width select
  //     [6]   absent, reads as one
  //     [7]   output level, same behaviour as the low side
  //   0x08 combined count, low counter in [7:0], high counter in [15:8]
  //     a write here lands in the combined reload too
  //   0x0C combined reload, same byte layout
  //   0x10 overflow status, [0] low and [1] high, write one to clear
  //   0x14 interrupt mask, same layout as status
  //   0x18 priority, [1:0] low and [3:2] high, stored for software only
  //   any other offset answers slverr and reads zero
  //
  // count clock select codes
  //   0 every timebase tick
  //   1 every 2nd tick
  //   2 every 4th tick
  //   3 every 8th tick
  //   4 every 32nd tick
  //   5 every 256th tick
  //   6 rising edge of the event input
  //   7 falling edge of the event input
  //
  // byte strobes: [0] writes bits 7:0 of any register, [1] writes bits
  // 15:8 of the count and reload words; higher strobes are ignored
  //
  // reset: counters and reloads clear, controls take 0x70 and 0x40,
  // status, mask, priority, pins and irq all clear

  // ========================================================================
  // state
  reg [7:0]  low_ctrl_q;
  reg [7:0]  high_ctrl_q;
  reg [7:0]  low_counter_q;
  reg [7:0]  high_counter_q;
  reg [7:0]  low_reload_q;
  reg [7:0]  high_reload_q;
  reg [1:0]  stat_q;
  reg [1:0]  mask_q;
  reg [3:0]  prio_q;
  reg        pwm_ff_q;
  reg        low_tog_q;
  reg        high_tog_q;
  reg        low_evt_q;
  reg        high_evt_q;
  reg [15:0] tbc_cnt_q;
  reg [7:0]  pre_q;
  reg        tick_q;

  // ========================================================================
  // count clock select: one enable pulse per selected rate
  function sel_tick;
    input [2:0] sel;
    input [7:0] pre;
    input       tick;
    input       rise;
    input       fall;
    begin
      case (sel)
        3'h0:    sel_tick = tick;
        3'h1:    sel_tick = tick & (pre[0] == 1'b1);
        3'h2:    sel_tick = tick & (pre[1:0] == 2'h3);
        3'h3:    sel_tick = tick & (pre[2:0] == 3'h7);
        3'h4:    sel_tick = tick & (pre[4:0] == 5'h1F);
        3'h5:    sel_tick = tick & (pre == 8'hFF);
        3'h6:    sel_tick = rise;
        default: sel_tick = fall;
      endcase
    end
  endfunction

  // timebase divider and prescaler; the prescaler free-runs so rates stay aligned
  always @(posedge clk) begin
    if (srst) begin
      tbc_cnt_q <= 16'h0000;
      pre_q     <= 8'h00;
      tick_q    <= 1'b0;
    end else if (tbc_cnt_q >= TBC_DIV[15:0] - 16'h0001) begin
      tbc_cnt_q <= 16'h0000;
      pre_q     <= pre_q + 8'h01;
      tick_q    <= 1'b1;
    end else begin
      tbc_cnt_q <= tbc_cnt_q + 16'h0001;
      tick_q    <= 1'b0;
    end
  end

  // event input history for edge detection (inputs taken as synchronous)
  always @(posedge clk) begin
    if (srst) begin
      low_evt_q  <= 1'b0;
      high_evt_q <= 1'b0;
    end else begin
      low_evt_q  <= low_event_input;
      high_evt_q <= high_event_input;
    end
  end

  // ========================================================================
  // mode summary
  //   independent: each side counts its own selected clock under its own
  //     run bit; an overflow sets its status bit, reloads that side only
  //     and flips that side's output level
  //   cascade: the high counter steps once per low overflow; the low side
  //     wraps to zero without reloading but still flags and flips; a high
  //     overflow reloads both bytes, flags high and flips the high level
  //   pwm: the high side sets the period and the low side the duty; a
  //     low overflow sets the flip-flop and a high overflow clears it and
  //     reloads both; if both come in one cycle the clear wins
  //   if both mode bits are written high, cascade takes precedence
  //
  // hazards and limits
  //   - software should give both sides the same count clock in pwm; a
  //     slower low clock shifts where the duty edge lands after each period
  //   - a faster low clock in pwm may overflow several times per period;
  //     each one sets the status bit, none is swallowed
  //   - event inputs must already be synchronous to clk; an edge is seen
  //     one cycle after the pin changes
  //   - a write to a counter wins over counting in that same cycle, so a
  //     tick that lands with the write is lost from the count while an overflow it raises still sets status and flips the level
  //   - an overflow that lands with a write-one clear keeps its status bit
  //     set, trading a rare stale clear for never dropping an event
  //   - pins and irq are registered, one cycle behind the internal state
  //   - the prescaler free-runs from reset, so the first tick after a run
  //     bit is set may come early by up to one prescaled period
  //   - priority bits only feed software; arbitration lives outside

  // ========================================================================
  // mode decode and counting enables
  wire casc_mode = high_ctrl_q[`DTP_CASC_BIT];
  wire pwm_mode  = high_ctrl_q[`DTP_PWM_BIT] & ~casc_mode;
  wire low_run   = low_ctrl_q[`DTP_RUN_BIT];
  // cascade and pwm ignore the high run bit; low run starts both
  wire high_run  = (casc_mode | pwm_mode) ? low_run : high_ctrl_q[`DTP_RUN_BIT];
  wire low_tick  = sel_tick(low_ctrl_q[`DTP_CSEL_MSB:0], pre_q, tick_q,
                            low_event_input & ~low_evt_q, ~low_event_input & low_evt_q);
  wire high_sel  = sel_tick(high_ctrl_q[`DTP_CSEL_MSB:0], pre_q, tick_q,
                            high_event_input & ~high_evt_q, ~high_event_input & high_evt_q);
  wire low_inc   = low_run & low_tick;
  wire low_ovf   = low_inc & (low_counter_q == 8'hFF);
  // cascade: high counter steps once per low overflow, its own clock ignored
  wire high_inc  = high_run & (casc_mode ? low_ovf : high_sel);
  wire high_ovf  = high_inc & (high_counter_q == 8'hFF);

  // ========================================================================
  // axi4-lite slave: address and data accepted together, one cycle each
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  wire wr_lo    = wr_go & s_axi_wstrb[0];
  wire wr_hi    = wr_go & s_axi_wstrb[1];
  wire wr_map   = (s_axi_awaddr == `DTP_OFF_LOW_CTRL) | (s_axi_awaddr == `DTP_OFF_HIGH_CTRL) |
                  (s_axi_awaddr == `DTP_OFF_COUNT) | (s_axi_awaddr == `DTP_OFF_RELOAD) |
                  (s_axi_awaddr == `DTP_OFF_IRQ_STAT) | (s_axi_awaddr == `DTP_OFF_IRQ_MASK) |
                  (s_axi_awaddr == `DTP_OFF_PRIORITY);
  wire wr_count  = (s_axi_awaddr == `DTP_OFF_COUNT);
  wire wr_reload = (s_axi_awaddr == `DTP_OFF_RELOAD);

  // write response: slverr on unmapped addresses
  always @(posedge clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control, mask and priority registers
  always @(posedge clk) begin
    if (srst) begin
      low_ctrl_q  <= `DTP_LOW_CTRL_RST;
      high_ctrl_q <= `DTP_HIGH_CTRL_RST;
      mask_q      <= 2'h0;
      prio_q      <= 4'h0;
    end else if (wr_lo) begin
      if (s_axi_awaddr == `DTP_OFF_LOW_CTRL)
        low_ctrl_q <= s_axi_wdata[7:0] | `DTP_LOW_CTRL_ONES;
      if (s_axi_awaddr == `DTP_OFF_HIGH_CTRL)
        high_ctrl_q <= s_axi_wdata[7:0] | `DTP_HIGH_CTRL_ONES;
      if (s_axi_awaddr == `DTP_OFF_IRQ_MASK)
        mask_q <= s_axi_wdata[1:0];
      if (s_axi_awaddr == `DTP_OFF_PRIORITY)
        prio_q <= s_axi_wdata[3:0];
    end
  end

  // counters; software writes win over counting in the same cycle
  always @(posedge clk) begin
    if (srst) begin
      low_counter_q <= 8'h00;
    end else if (wr_lo & wr_count) begin
      low_counter_q <= s_axi_wdata[7:0];
    end else if (low_ovf & ~casc_mode & ~(pwm_mode & high_ovf)) begin
      low_counter_q <= low_reload_q;
    end else if (high_ovf & (casc_mode | pwm_mode)) begin
      low_counter_q <= low_reload_q;
    end else if (low_inc) begin
      low_counter_q <= low_counter_q + 8'h01; // wraps to zero in cascade
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      high_counter_q <= 8'h00;
    end else if (wr_hi & wr_count) begin
      high_counter_q <= s_axi_wdata[15:8];
    end else if (high_ovf) begin
      high_counter_q <= high_reload_q;
    end else if (high_inc) begin
      high_counter_q <= high_counter_q + 8'h01;
    end
  end

  // reload registers: a counter write loads the same value here too
  always @(posedge clk) begin
    if (srst) begin
      low_reload_q  <= 8'h00;
      high_reload_q <= 8'h00;
    end else begin
      if (wr_lo & (wr_count | wr_reload))
        low_reload_q <= s_axi_wdata[7:0];
      if (wr_hi & (wr_count | wr_reload))
        high_reload_q <= s_axi_wdata[15:8];
    end
  end

  // ========================================================================
  // output toggles; a control write reloads the initial level
  wire low_ctrl_wr  = wr_lo & (s_axi_awaddr == `DTP_OFF_LOW_CTRL);
  wire high_ctrl_wr = wr_lo & (s_axi_awaddr == `DTP_OFF_HIGH_CTRL);
  always @(posedge clk) begin
    if (srst) begin
      low_tog_q  <= 1'b0;
      high_tog_q <= 1'b0;
    end else begin
      if (low_ctrl_wr)
        low_tog_q <= s_axi_wdata[`DTP_OUT_BIT];
      else if (low_ovf)
        low_tog_q <= ~low_tog_q;
      if (high_ctrl_wr)
        high_tog_q <= s_axi_wdata[`DTP_OUT_BIT];
      else if (high_ovf)
        high_tog_q <= ~high_tog_q;
    end
  end

  // pwm flip-flop: reset beats set in the same cycle
  always @(posedge clk) begin
    if (srst)
      pwm_ff_q <= 1'b0;
    else if (pwm_mode & high_ovf)
      pwm_ff_q <= 1'b0;
    else if (pwm_mode & low_ovf)
      pwm_ff_q <= 1'b1;
  end

  // pin drivers: pwm shows true and inverted phase of the flip-flop
  always @(posedge clk) begin
    if (srst) begin
      low_output  <= 1'b0;
      high_output <= 1'b0;
    end else if (pwm_mode) begin
      low_output  <= pwm_ff_q;
      high_output <= ~pwm_ff_q;
    end else begin
      low_output  <= low_tog_q;
      high_output <= high_tog_q;
    end
  end

  // ========================================================================
  // sticky request flags; every overflow sets, set beats write-one clear
  wire [1:0] clr = (wr_lo & (s_axi_awaddr == `DTP_OFF_IRQ_STAT)) ? s_axi_wdata[1:0] : 2'h0;
  always @(posedge clk) begin
    if (srst) begin
      stat_q <= 2'h0;
      irq    <= 1'b0;
    end else begin
      stat_q[0] <= low_ovf | (stat_q[0] & ~clr[0]);
      stat_q[1] <= high_ovf | (stat_q[1] & ~clr[1]);
      irq       <= |(stat_q & mask_q);
    end
  end

  // ========================================================================
  // read data
  always @(posedge clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        `DTP_OFF_LOW_CTRL:
          s_axi_rdata <= {24'h000000, low_tog_q, low_ctrl_q[6:0]};
        `DTP_OFF_HIGH_CTRL:
          s_axi_rdata <= {24'h000000, high_tog_q, high_ctrl_q[6:0]};
        `DTP_OFF_COUNT:
          s_axi_rdata <= {16'h0000, high_counter_q, low_counter_q};
        `DTP_OFF_RELOAD:
          s_axi_rdata <= {16'h0000, high_reload_q, low_reload_q};
        `DTP_OFF_IRQ_STAT:
          s_axi_rdata <= {30'h00000000, stat_q};
        `DTP_OFF_IRQ_MASK:
          s_axi_rdata <= {30'h00000000, mask_q};
        `DTP_OFF_PRIORITY:
          s_axi_rdata <= {28'h0000000, prio_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // dtp_timer_pair

// ---- pkg/dtp_defs.vh ----
// register offsets, field positions, reset values and timing constants for the paired timer
// ==========================================================================
// What this block does
// - counter write also writes reload register
// - control one: clock select, run, output level
// - cascade bit joins counters, low run starts
// - pulse width bit, low run starts both
// - independent mode: count, interrupt, reload, toggle
// - cascade: high counts low overflows, reloads both
// - cascade low overflow: no reload, interrupt, toggle
// - pwm low overflow: interrupt, set flip-flop
// - pwm high overflow: interrupt, reload, reset
// - flip-flop reset wins over set
// - pwm: low pin true, high pin inverted
// - repeated low overflows all raise interrupts
// - low overflow sets low request flag
// - high overflow sets high request flag
// - high output starts programmed, inverts on overflow
`ifndef DTP_DEFS_VH
`define DTP_DEFS_VH
// ==========================================================================
// register byte offsets
`define DTP_OFF_LOW_CTRL   8'h00
`define DTP_OFF_HIGH_CTRL  8'h04
`define DTP_OFF_COUNT      8'h08
`define DTP_OFF_RELOAD     8'h0C
`define DTP_OFF_IRQ_STAT   8'h10
`define DTP_OFF_IRQ_MASK   8'h14
`define DTP_OFF_PRIORITY   8'h18
// control fields
`define DTP_CSEL_MSB       2
`define DTP_RUN_BIT        3
`define DTP_CASC_BIT       4
`define DTP_PWM_BIT        5
`define DTP_OUT_BIT        7
// reset values; absent bits of both controls read as one
`define DTP_LOW_CTRL_RST   8'h70
`define DTP_HIGH_CTRL_RST  8'h40
`define DTP_LOW_CTRL_ONES  8'h70
`define DTP_HIGH_CTRL_ONES 8'h40
// vectors of the two overflow interrupts
`define DTP_VEC_LOW        16'h0022
`define DTP_VEC_HIGH       16'h0024
// timebase: clock period in ns and timebase tick in ns
`define DTP_CLK_NS         8
`define DTP_TBC_NS         8
`define DTP_TBC_CYC        ((`DTP_TBC_NS + `DTP_CLK_NS - 1) / `DTP_CLK_NS)
`endif

// ---- verif/dtp_monitor.sv ----
// assertion checker watching the timer pair's bus and pin ports
`timescale 1ns/1ps
`include "dtp_defs.vh"
module dtp_monitor (
  // clock and reset
  input logic        clk,
  input logic        srst,
  // register bus
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [7:0]  s_axi_awaddr,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0]  s_axi_wstrb,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  // pins and interrupt
  input logic        low_event_input,
  input logic        high_event_input,
  input logic        low_output,
  input logic        high_output,
  input logic        irq
);
  // ==========================================================================
  // helper: pwm mode as last written, cascade wins when both bits are set
  logic wr_go;
  logic pwm_q;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  always @(posedge clk) begin
    if (srst)
      pwm_q <= 1'b0;
    else if (wr_go && s_axi_awaddr == `DTP_OFF_HIGH_CTRL && s_axi_wstrb[0])
      pwm_q <= s_axi_wdata[5] & ~s_axi_wdata[4];
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence wr_take_s; wr_go; endsequence
  sequence rd_take_s; s_axi_arvalid && s_axi_arready; endsequence
  sequence mask_off_s;
    wr_go && s_axi_awaddr == `DTP_OFF_IRQ_MASK && s_axi_wstrb[0] && s_axi_wdata[1:0] == 2'b00;
  endsequence
  write_answer_a: assert property (wr_take_s |=> s_axi_bvalid)
    else $error("write answer missing");
  read_answer_a: assert property (rd_take_s |=> s_axi_rvalid)
    else $error("read answer missing");
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  ready_pair_a: assert property (s_axi_awready == s_axi_wready)
    else $error("address and data ready differ");
  read_error_a: assert property (rd_take_s ##0 s_axi_araddr > `DTP_OFF_PRIORITY
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  write_error_a: assert property (wr_take_s ##0 s_axi_awaddr > `DTP_OFF_PRIORITY
    |=> s_axi_bresp == 2'h2) else $error("unmapped write answered");
  pwm_pins_a: assert property (pwm_q && $past(pwm_q, 3) |-> low_output != high_output)
    else $error("pwm pins not complementary");
  mask_gate_a: assert property (mask_off_s |-> ##2 !irq)
    else $error("masked interrupt still raised");
endmodule // dtp_monitor

bind dtp_timer_pair dtp_monitor mon (.*);

// ---- verif/dtp_pins_model.sv ----
// pin-side model: event sources feeding the timer inputs
`timescale 1ns/1ps
module dtp_pins_model (
  // clock
  input  logic clk,
  // event lines toward the timer, timer pins back
  output logic low_event_input,
  output logic high_event_input,
  input  logic low_output,
  input  logic high_output
);
  // lines idle low; each pulse gives one clean rising edge per selected line
  initial begin
    low_event_input = 1'b0;
    high_event_input = 1'b0;
  end
  task automatic pulse(input logic [1:0] which, input int n);
    repeat (n) begin
      @(posedge clk);
      {high_event_input, low_event_input} <= which;
      @(posedge clk);
      {high_event_input, low_event_input} <= 2'b00;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule // dtp_pins_model

// ---- verif/tb_top.sv ----
// self-checking bench for the paired timer block
`timescale 1ns/1ps
`include "dtp_defs.vh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); fail_count++; end end
module tb_top;
  // ==========================================================================
  // signals
  logic        clk = 0, srst = 1;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         low_event_input, high_event_input, low_output, high_output, irq;
  int          fail_count = 0, num_checks = 0, cyc = 0;
  localparam [7:0] a_lc = `DTP_OFF_LOW_CTRL, a_hc = `DTP_OFF_HIGH_CTRL;
  localparam [7:0] a_cn = `DTP_OFF_COUNT, a_rl = `DTP_OFF_RELOAD;
  localparam [7:0] a_st = `DTP_OFF_IRQ_STAT, a_mk = `DTP_OFF_IRQ_MASK;
  dtp_timer_pair #(.TBC_DIV(1)) uut (.*);
  dtp_pins_model pins (.*);
  initial forever #4 clk = ~clk;
  // hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ==========================================================================
  // bus tasks: hold each request until its ready is sampled high
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do @(posedge clk); while (!s_axi_awready);
    {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic rdr(input logic [7:0] a, input logic [15:0] ex, input logic [1:0] er = 2'h0);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK("rresp", er, s_axi_rresp)
    `CHK("rdata", ex, s_axi_rdata[15:0])
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rdr(a_lc, 16'h0070);
    rdr(a_hc, 16'h0040);
    rdr(8'h20, 16'h0000, 2'h2);
    wr(8'h20, 32'h0, 2'h2);
    wr(`DTP_OFF_PRIORITY, 32'hB);
    rdr(`DTP_OFF_PRIORITY, 16'h000B);
  endtask
  task automatic t_presc();
    // slowest prescaled clock: one overflow from FF within 256 cycles
    wr(a_hc, 32'h05);
    wr(a_cn, 32'hFF00);
    wr(a_st, 32'h3);
    wr(a_hc, 32'h0D);
    repeat (300) @(posedge clk);
    rdr(a_st, 16'h0002);
    wr(a_hc, 32'h05);
  endtask
  task automatic t_load();
    wr(a_cn, 32'h12AB);
    rdr(a_rl, 16'h12AB);
    wr(a_rl, 32'h3456);
    rdr(a_cn, 16'h12AB);
    s_axi_wstrb <= 4'h1;
    wr(a_cn, 32'h0077);
    s_axi_wstrb <= 4'hF;
    rdr(a_cn, 16'h1277);
    rdr(a_rl, 16'h3477);
  endtask
  task automatic t_indep();
    wr(a_hc, 32'h0);
    wr(a_cn, 32'h00FE);
    wr(a_st, 32'h3);
    wr(a_lc, 32'h0E);
    pins.pulse(2'b01, 2);
    rdr(a_st, 16'h0001);
    rdr(a_cn, 16'h00FE);
    rdr(a_lc, 16'h00FE);
    `CHK("low_output", 1'b1, low_output)
    wr(a_mk, 32'h1);
    repeat (3) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    wr(a_st, 32'h1);
    repeat (3) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    wr(a_mk, 32'h0);
    pins.pulse(2'b01, 2);
    rdr(a_st, 16'h0001);
    `CHK("irq", 1'b0, irq)
    `CHK("low_output", 1'b0, low_output)
  endtask
  task automatic t_casc();
    // high clock select left at the free-running tick: cascade must ignore it
    wr(a_hc, 32'h10);
    wr(a_cn, 32'h00FE);
    wr(a_rl, 32'h1234);
    wr(a_st, 32'h3);
    wr(a_lc, 32'h0E);
    pins.pulse(2'b01, 2);
    rdr(a_st, 16'h0001);
    rdr(a_cn, 16'h0100);
    `CHK("low_output", 1'b1, low_output)
    wr(a_cn, 32'hFFFE);
    wr(a_rl, 32'h1234);
    wr(a_st, 32'h3);
    pins.pulse(2'b01, 2);
    rdr(a_st, 16'h0003);
    rdr(a_cn, 16'h1234);
    rdr(a_hc, 16'h00D0);
    `CHK("high_output", 1'b1, high_output)
    `CHK("low_output", 1'b0, low_output)
  endtask
  task automatic t_pwm();
    // both counters on event clocks of the same kind
    wr(a_hc, 32'h26);
    wr(a_cn, 32'hFEFE);
    wr(a_st, 32'h3);
    wr(a_lc, 32'h0E);
    pins.pulse(2'b01, 2);
    rdr(a_st, 16'h0001);
    `CHK("low_output", 1'b1, low_output)
    `CHK("high_output", 1'b0, high_output)
    pins.pulse(2'b10, 2);
    rdr(a_st, 16'h0003);
    rdr(a_cn, 16'hFEFE);
    `CHK("low_output", 1'b0, low_output)
    wr(a_cn, 32'hFFFF);
    pins.pulse(2'b11, 1);
    repeat (2) @(posedge clk);
    `CHK("low_output", 1'b0, low_output)
    `CHK("high_output", 1'b1, high_output)
  endtask
  // ==========================================================================
  // closing report
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_load();
    t_indep();
    t_casc();
    t_pwm();
    t_presc();
    report_and_stop();
  end
endmodule // tb_top
